// ### rtl/iats_cfg.svh
// Purpose: Constants for the interrupt acknowledge and context block (offsets, fields, resets, timing).
// Assumes: 32-bit APB, byte addresses, one phase per i_mclk cycle, two phases per state time.
// Notes: Included by the design files; definitions only.
//
// Notes on behaviour
// - Nonmaskable input and timer capture request are sampled in phase 1.
// - External request on port0_bit7_pin is sampled in phase 2.
// - After server enable or disable, no acknowledge until the next instruction completes.
// - Server disable turns the transaction server off; server enable turns it on.
// - Context save pushes status word, both masks, window select; then clears word and masks.
// - Status word holds global enable and server enable bits beside arithmetic flags.
// - Context restore reloads status word, both masks and window select from the stack.
// - Standard forced call response takes 11 state times internal stack, 13 external.
// - Worst case request to service start is at most 56 state times.
// - Server control bits 7..5: 000 block, 001 output, 011 input, 100 single transfer.
// - Remaining server control bits mean different fields depending on the selected mode.
// - Reserved window select value misbehaves; only reset or context restore repairs it.
// - Server mode bits 110 select the analogue conversion scan mode.
`ifndef IATS_CFG_SVH
`define IATS_CFG_SVH

`define IATS_NSRC          16
`define IATS_OFF_CMD       8'h00
`define IATS_OFF_PSW       8'h04
`define IATS_OFF_MASK_LO   8'h08
`define IATS_OFF_MASK_HI   8'h0c
`define IATS_OFF_WSR       8'h10
`define IATS_OFF_SRVCON    8'h14
`define IATS_OFF_CFG       8'h18
`define IATS_OFF_STATUS    8'h1c
`define IATS_OFF_EVT       8'h20
`define IATS_OFF_EVT_MASK  8'h24
`define IATS_OFF_PENDING   8'h28

`define IATS_CMD_SAVE      0
`define IATS_CMD_RESTORE   1
`define IATS_CMD_SRV_EN    2
`define IATS_CMD_SRV_DIS   3

`define IATS_PSW_I_BIT     9
`define IATS_PSW_PSE_BIT   10
`define IATS_CFG_EXTSTK    0

`define IATS_EV_ACK        0
`define IATS_EV_LATENCY    1
`define IATS_EV_STACK      2
`define IATS_EV_WSR        3
`define IATS_NEVT          4

`define IATS_PSW_RST       16'h0000
`define IATS_MASK_RST      8'h00
`define IATS_WSR_RST       8'h00
`define IATS_SRVCON_RST    8'h00

`define IATS_MODE_BLOCK    3'b000
`define IATS_MODE_HSO      3'b001
`define IATS_MODE_HSI      3'b011
`define IATS_MODE_SINGLE   3'b100
`define IATS_MODE_SCAN     3'b110

`define IATS_PHASES_PER_ST 2
`define IATS_RESP_INT_ST   11
`define IATS_RESP_EXT_ST   13
`define IATS_LAT_MAX_ST    56

`endif

// ### rtl/iats_pkg.sv
// Purpose: Types shared by the interrupt acknowledge and context block.
// Assumes: Constants come from iats_cfg.svh.
// Notes: Holds types only.
`include "iats_cfg.svh"

package iats_pkg;

    typedef struct packed {
        logic [15:0] processor_status_word;
        logic [7:0]  mask_lo;
        logic [7:0]  mask_hi;
        logic [7:0]  window_select_register;
    } iats_ctx_type;

    typedef enum logic [2:0] {
        IATS_SRV_BLOCK  = `IATS_MODE_BLOCK,
        IATS_SRV_HSO    = `IATS_MODE_HSO,
        IATS_SRV_HSI    = `IATS_MODE_HSI,
        IATS_SRV_SINGLE = `IATS_MODE_SINGLE,
        IATS_SRV_SCAN   = `IATS_MODE_SCAN,
        IATS_SRV_RSVD   = 3'b111
    } iats_srv_mode_type;

    typedef struct packed {
        iats_srv_mode_type mode;
        logic              xfer_layout;
        logic              hs_layout;
        logic [4:0]        low_bits;
    } iats_srv_type;

    typedef enum logic [1:0] {
        IATS_ST_IDLE = 2'b01,
        IATS_ST_CALL = 2'b10
    } iats_state_type;

endpackage : iats_pkg

// ### rtl/iats_sampler.sv
// Purpose: Phase-selected request sampling with sticky pending bits.
// Assumes: Requests are synchronous to i_mclk and held longer than one state time.
// Notes: A new edge in the same cycle as its acknowledge clear keeps the bit set.
`timescale 1ns/100ps
`default_nettype none

module iats_sampler #(
    parameter int W = 17
) (
    input  wire logic         i_mclk,
    input  wire logic         i_rst_n,
    input  wire logic         i_ce,
    input  wire logic         i_phase2,
    input  wire logic [W-1:0] i_req,
    input  wire logic [W-1:0] i_phase1_sel,
    input  wire logic [W-1:0] i_ack_clr,
    output logic      [W-1:0] o_pending
);
    logic [W-1:0] samp_q;
    logic [W-1:0] pend_q;
    logic [W-1:0] take;
    logic [W-1:0] rise;

    // Phase 1 sources look only when i_phase2 is low, phase 2 sources only when it is high.
    assign take = i_phase2 ? ~i_phase1_sel : i_phase1_sel;
    assign rise = take & i_req & ~samp_q;

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            samp_q <= '0;
        end else if (i_ce) begin
            samp_q <= (take & i_req) | (~take & samp_q);
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            pend_q <= '0;
        end else if (i_ce) begin
            pend_q <= (pend_q & ~i_ack_clr) | rise;
        end
    end

    assign o_pending = pend_q;

endmodule : iats_sampler

`default_nettype wire

// ### rtl/iats_top.sv
// Purpose: Interrupt acknowledge, forced call timing, context save and restore, server control decode.
// Assumes: One phase per clock; core pulses i_instr_done when an instruction completes.
// Notes: Registers on APB; pready is always high, read data is captured in the setup cycle.
`timescale 1ns/100ps
`default_nettype none

module iats_top #(
    parameter int          STACK_DEPTH = 4,
    parameter logic [7:0]  WSR_MAX     = 8'h1f,
    parameter logic [15:0] PHASE1_SRC  = 16'h0001
) (
    input  wire logic                 i_mclk,
    input  wire logic                 i_rst_n,
    input  wire logic                 i_ce,
    input  wire logic                 i_psel,
    input  wire logic                 i_penable,
    input  wire logic                 i_pwrite,
    input  wire logic [7:0]           i_paddr,
    input  wire logic [31:0]          i_pwdata,
    output logic      [31:0]          o_prdata,
    output logic                      o_pready,
    output logic                      o_pslverr,
    input  wire logic [15:0]          i_req,
    input  wire logic                 i_nmi,
    input  wire logic                 i_instr_done,
    output logic                      o_svc_start,
    output logic      [4:0]           o_svc_vector,
    output logic                      o_call_busy,
    output logic                      o_server_enable,
    output logic                      o_global_enable,
    output iats_pkg::iats_srv_type    o_srv_fields,
    output logic                      o_wsr_bad,
    output logic                      o_irq
);
    import iats_pkg::*;

    localparam int SPW = $clog2(STACK_DEPTH + 1);

    function automatic logic is_mapped(input logic [7:0] a);
        return a inside {`IATS_OFF_CMD, `IATS_OFF_PSW, `IATS_OFF_MASK_LO, `IATS_OFF_MASK_HI,
                         `IATS_OFF_WSR, `IATS_OFF_SRVCON, `IATS_OFF_CFG, `IATS_OFF_STATUS,
                         `IATS_OFF_EVT, `IATS_OFF_EVT_MASK, `IATS_OFF_PENDING};
    endfunction : is_mapped

    // Highest pending index wins; NMI is handled ahead of this.
    function automatic logic [4:0] top_index(input logic [15:0] v);
        logic [4:0] r;
        r = 5'h00;
        for (int k = 0; k < 16; k++) begin
            if (v[k]) begin
                r = 5'(k);
            end
        end
        return r;
    endfunction : top_index

    function automatic iats_srv_type decode_srv(input logic [7:0] c);
        iats_srv_type s;
        s.mode        = iats_srv_mode_type'(c[7:5]);
        s.low_bits    = c[4:0];
        s.xfer_layout = (c[7:5] == `IATS_MODE_BLOCK) || (c[7:5] == `IATS_MODE_SINGLE);
        s.hs_layout   = (c[7:5] == `IATS_MODE_HSO) || (c[7:5] == `IATS_MODE_HSI) ||
                        (c[7:5] == `IATS_MODE_SCAN);
        if (!(s.xfer_layout || s.hs_layout)) begin
            s.mode = IATS_SRV_RSVD;
        end
        return s;
    endfunction : decode_srv

    logic [15:0]       psw_q;
    logic [7:0]        mask_lo_q;
    logic [7:0]        mask_hi_q;
    logic [7:0]        wsr_q;
    logic              wsr_bad_q;
    logic [7:0]        srvcon_q;
    logic              cfg_extstk_q;
    iats_ctx_type      stack_q [STACK_DEPTH];
    logic [SPW-1:0]    sp_q;
    logic              inhibit_q;
    logic              phase_q;
    iats_state_type    state_q;
    logic [5:0]        resp_cnt_q;
    logic [5:0]        lat_cnt_q;
    logic              svc_start_q;
    logic [4:0]        svc_vec_q;
    logic [4:0]        sel_vec_q;
    logic [`IATS_NEVT-1:0] evt_q;
    logic [`IATS_NEVT-1:0] evt_mask_q;
    logic [31:0]       prdata_q;
    logic              pslverr_q;

    logic              wr_en;
    logic              rd_setup;
    logic [16:0]       pending;
    logic [16:0]       ack_clr;
    logic [15:0]       enabled;
    logic              eligible;
    logic              accept;
    logic              tick;
    logic              cmd_save;
    logic              cmd_restore;
    logic              cmd_srv;
    logic              stk_err;
    logic              wsr_err;
    logic              lat_err;
    logic [`IATS_NEVT-1:0] evt_set;
    iats_ctx_type      cur_ctx;

    assign wr_en    = i_psel && i_penable && i_pwrite && i_ce;
    assign rd_setup = i_psel && !i_penable;
    assign tick     = i_ce && phase_q;

    assign cmd_save    = wr_en && (i_paddr == `IATS_OFF_CMD) && i_pwdata[`IATS_CMD_SAVE];
    assign cmd_restore = wr_en && (i_paddr == `IATS_OFF_CMD) && i_pwdata[`IATS_CMD_RESTORE] && !cmd_save;
    assign cmd_srv     = wr_en && (i_paddr == `IATS_OFF_CMD) &&
                         (i_pwdata[`IATS_CMD_SRV_EN] || i_pwdata[`IATS_CMD_SRV_DIS]);

    iats_sampler #(
        .W (17)
    ) u_sampler (
        .i_mclk       (i_mclk),
        .i_rst_n      (i_rst_n),
        .i_ce         (i_ce),
        .i_phase2     (phase_q),
        .i_req        ({i_nmi, i_req}),
        .i_phase1_sel ({1'b1, PHASE1_SRC}),
        .i_ack_clr    (ack_clr),
        .o_pending    (pending)
    );

    // A state time is two clocks: phase_q low is phase 1, high is phase 2.
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            phase_q <= 1'b0;
        end else if (i_ce) begin
            phase_q <= ~phase_q;
        end
    end

    assign enabled  = pending[15:0] & {mask_hi_q, mask_lo_q};
    assign eligible = pending[16] || (psw_q[`IATS_PSW_I_BIT] && (|enabled));
    assign accept   = i_ce && (state_q == IATS_ST_IDLE) && !inhibit_q && eligible;

    always_comb begin
        ack_clr = '0;
        if (accept) begin
            if (pending[16]) begin
                ack_clr[16] = 1'b1;
            end else begin
                ack_clr[top_index(enabled)] = 1'b1;
            end
        end
    end

    // Inhibit is raised by either server instruction and dropped when the next one completes.
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            inhibit_q <= 1'b0;
        end else if (i_ce) begin
            if (cmd_srv) begin
                inhibit_q <= 1'b1;
            end else if (i_instr_done) begin
                inhibit_q <= 1'b0;
            end
        end
    end

    // Forced call: the response counts whole state times before the service routine starts.
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            state_q     <= IATS_ST_IDLE;
            resp_cnt_q  <= 6'h00;
            sel_vec_q   <= 5'h00;
            svc_start_q <= 1'b0;
            svc_vec_q   <= 5'h00;
        end else if (i_ce) begin
            svc_start_q <= 1'b0;
            unique case (state_q)
                IATS_ST_IDLE: begin
                    if (accept) begin
                        state_q    <= IATS_ST_CALL;
                        sel_vec_q  <= pending[16] ? 5'h10 : top_index(enabled);
                        resp_cnt_q <= cfg_extstk_q ? 6'(`IATS_RESP_EXT_ST) : 6'(`IATS_RESP_INT_ST);
                    end
                end
                IATS_ST_CALL: begin
                    if (tick) begin
                        resp_cnt_q <= resp_cnt_q - 6'h01;
                        if (resp_cnt_q == 6'h01) begin
                            state_q     <= IATS_ST_IDLE;
                            svc_start_q <= 1'b1;
                            svc_vec_q   <= sel_vec_q;
                        end
                    end
                end
            endcase
        end
    end

    // Latency from an eligible request to service start; overrun beyond the bound is flagged.
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            lat_cnt_q <= 6'h00;
        end else if (i_ce) begin
            if (svc_start_q) begin
                lat_cnt_q <= 6'h00;
            end else if (tick && (eligible || state_q == IATS_ST_CALL) && lat_cnt_q != 6'h3f) begin
                lat_cnt_q <= lat_cnt_q + 6'h01;
            end
        end
    end
    assign lat_err = tick && (lat_cnt_q == 6'(`IATS_LAT_MAX_ST)) && !svc_start_q;

    assign cur_ctx = '{processor_status_word: psw_q, mask_lo: mask_lo_q, mask_hi: mask_hi_q, window_select_register: wsr_q};
    assign stk_err = (cmd_save && sp_q == SPW'(STACK_DEPTH)) || (cmd_restore && sp_q == '0);
    assign wsr_err = wr_en && (i_paddr == `IATS_OFF_WSR) && !wsr_bad_q && (i_pwdata[7:0] > WSR_MAX);

    // Context registers; save and restore go through a flip-flop stack indexed by sp_q.
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            psw_q     <= `IATS_PSW_RST;
            mask_lo_q <= `IATS_MASK_RST;
            mask_hi_q <= `IATS_MASK_RST;
            wsr_q     <= `IATS_WSR_RST;
            wsr_bad_q <= 1'b0;
            sp_q      <= '0;
        end else if (i_ce) begin
            if (cmd_save && !stk_err) begin
                stack_q[sp_q[$clog2(STACK_DEPTH)-1:0]] <= cur_ctx;
                sp_q      <= sp_q + SPW'(1);
                psw_q     <= `IATS_PSW_RST;
                mask_lo_q <= `IATS_MASK_RST;
                mask_hi_q <= `IATS_MASK_RST;
            end else if (cmd_restore && !stk_err) begin
                psw_q     <= stack_q[sp_q[$clog2(STACK_DEPTH)-1:0] - 1'b1].processor_status_word;
                mask_lo_q <= stack_q[sp_q[$clog2(STACK_DEPTH)-1:0] - 1'b1].mask_lo;
                mask_hi_q <= stack_q[sp_q[$clog2(STACK_DEPTH)-1:0] - 1'b1].mask_hi;
                wsr_q     <= stack_q[sp_q[$clog2(STACK_DEPTH)-1:0] - 1'b1].window_select_register;
                wsr_bad_q <= stack_q[sp_q[$clog2(STACK_DEPTH)-1:0] - 1'b1].window_select_register > WSR_MAX;
                sp_q      <= sp_q - SPW'(1);
            end else if (wr_en) begin
                unique case (i_paddr)
                    `IATS_OFF_CMD: begin
                        if (i_pwdata[`IATS_CMD_SRV_DIS]) begin
                            psw_q[`IATS_PSW_PSE_BIT] <= 1'b0;
                        end else if (i_pwdata[`IATS_CMD_SRV_EN]) begin
                            psw_q[`IATS_PSW_PSE_BIT] <= 1'b1;
                        end
                    end
                    `IATS_OFF_PSW:     psw_q     <= i_pwdata[15:0];
                    `IATS_OFF_MASK_LO: mask_lo_q <= i_pwdata[7:0];
                    `IATS_OFF_MASK_HI: mask_hi_q <= i_pwdata[7:0];
                    `IATS_OFF_WSR: begin
                        // Once a reserved window is loaded, writes cannot repair it.
                        if (!wsr_bad_q) begin
                            wsr_q     <= i_pwdata[7:0];
                            wsr_bad_q <= wsr_err;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            srvcon_q     <= `IATS_SRVCON_RST;
            cfg_extstk_q <= 1'b0;
            evt_mask_q   <= '0;
        end else if (wr_en) begin
            if (i_paddr == `IATS_OFF_SRVCON) begin
                srvcon_q <= i_pwdata[7:0];
            end
            if (i_paddr == `IATS_OFF_CFG) begin
                cfg_extstk_q <= i_pwdata[`IATS_CFG_EXTSTK];
            end
            if (i_paddr == `IATS_OFF_EVT_MASK) begin
                evt_mask_q <= i_pwdata[`IATS_NEVT-1:0];
            end
        end
    end

    assign evt_set = {wsr_err, stk_err, lat_err, svc_start_q};

    // Write one to clear; a new event in the same cycle survives the clear.
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            evt_q <= '0;
        end else if (i_ce) begin
            if (wr_en && i_paddr == `IATS_OFF_EVT) begin
                evt_q <= (evt_q & ~i_pwdata[`IATS_NEVT-1:0]) | evt_set;
            end else begin
                evt_q <= evt_q | evt_set;
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (i_ce && rd_setup) begin
            pslverr_q <= !is_mapped(i_paddr);
            unique case (i_paddr)
                `IATS_OFF_PSW:      prdata_q <= {16'h0000, psw_q};
                `IATS_OFF_MASK_LO:  prdata_q <= {24'h000000, mask_lo_q};
                `IATS_OFF_MASK_HI:  prdata_q <= {24'h000000, mask_hi_q};
                `IATS_OFF_WSR:      prdata_q <= {24'h000000, wsr_q};
                `IATS_OFF_SRVCON:   prdata_q <= {24'h000000, srvcon_q};
                `IATS_OFF_CFG:      prdata_q <= {31'h0000_0000, cfg_extstk_q};
                `IATS_OFF_STATUS:   prdata_q <= {16'h0000, 8'(sp_q), 2'b00, lat_cnt_q > 6'(`IATS_LAT_MAX_ST),
                                                 wsr_bad_q, inhibit_q, state_q == IATS_ST_CALL, phase_q, 1'b0};
                `IATS_OFF_EVT:      prdata_q <= {28'h000_0000, evt_q};
                `IATS_OFF_EVT_MASK: prdata_q <= {28'h000_0000, evt_mask_q};
                `IATS_OFF_PENDING:  prdata_q <= {15'h0000, pending};
                default:            prdata_q <= 32'h0000_0000;
            endcase
        end
    end

    assign o_prdata        = prdata_q;
    assign o_pready        = 1'b1;
    assign o_pslverr       = pslverr_q & i_psel & i_penable;
    assign o_svc_start     = svc_start_q;
    assign o_svc_vector    = svc_vec_q;
    assign o_call_busy     = (state_q == IATS_ST_CALL);
    assign o_server_enable = psw_q[`IATS_PSW_PSE_BIT];
    assign o_global_enable = psw_q[`IATS_PSW_I_BIT];
    assign o_srv_fields    = decode_srv(srvcon_q);
    assign o_wsr_bad       = wsr_bad_q;
    assign o_irq           = |(evt_q & evt_mask_q);

endmodule : iats_top

`default_nettype wire

// ### test/iats_chk_props.sv
// Purpose: Port-level checks of iats_top.
// Assumes: One clock, synchronous active-low reset.
// Notes: Bound to every iats_top at the foot of this file.
`timescale 1ns/100ps
`default_nettype none
`include "iats_cfg.svh"

module iats_chk #(
    parameter logic [7:0] WSR_MAX = 8'h1f
) (
    input wire logic                   i_mclk,
    input wire logic                   i_rst_n,
    input wire logic                   i_ce,
    input wire logic                   i_psel,
    input wire logic                   i_penable,
    input wire logic                   i_pwrite,
    input wire logic [7:0]             i_paddr,
    input wire logic [31:0]            i_pwdata,
    input wire logic                   i_instr_done,
    input wire logic                   o_svc_start,
    input wire logic                   o_call_busy,
    input wire logic                   o_server_enable,
    input wire logic                   o_global_enable,
    input wire iats_pkg::iats_srv_type o_srv_fields,
    input wire logic                   o_wsr_bad
);
    import iats_pkg::*;
    default clocking dc @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_n);
    wire logic wr = i_psel && i_penable && i_pwrite && i_ce;
    wire logic cmd = wr && (i_paddr == `IATS_OFF_CMD);
    // Tracks stack depth so that a save refused on a full stack is not held against the design.
    logic [2:0] save_depth_q;
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            save_depth_q <= 3'h0;
        end else if (cmd && i_pwdata[0] && save_depth_q != 3'h4) begin
            save_depth_q <= save_depth_q + 3'h1;
        end else if (cmd && !i_pwdata[0] && i_pwdata[1] && save_depth_q != 3'h0) begin
            save_depth_q <= save_depth_q - 3'h1;
        end
    end
    sequence s_call;
        $rose(o_call_busy);
    endsequence
    // Not early, and no later than the external stack allows.
    sequence s_served;
        !o_svc_start [*8] ##[12:20] o_svc_start;
    endsequence
    AST_CALL_TIME: assert property (s_call |-> s_served)
        else $error("forced call length out of range");
    // Starts one cycle late so that an accept at the command edge itself is allowed.
    AST_INHIBIT: assert property (cmd && i_pwdata[3:2] != 2'b00 |=> ##1 (!$rose(o_call_busy) until i_instr_done))
        else $error("call accepted before next instruction completed");
    AST_SRV_ON: assert property (cmd && i_pwdata[3:0] == 4'h4 |=> o_server_enable)
        else $error("server not enabled");
    AST_SRV_OFF: assert property (cmd && i_pwdata[3:0] == 4'h8 |=> !o_server_enable)
        else $error("server not disabled");
    AST_SAVE: assert property (cmd && i_pwdata[3:0] == 4'h1 && save_depth_q != 3'h4 |=> !o_global_enable && !o_server_enable)
        else $error("status word not cleared by save");
    AST_XFER: assert property (o_srv_fields.mode inside {IATS_SRV_BLOCK, IATS_SRV_SINGLE} |->
        o_srv_fields.xfer_layout && !o_srv_fields.hs_layout)
        else $error("transfer layout not selected");
    AST_WSR_BAD: assert property (wr && i_paddr == `IATS_OFF_WSR && i_pwdata[7:0] > WSR_MAX |=> o_wsr_bad)
        else $error("reserved window value not flagged");
    AST_WSR_HOLD: assert property (o_wsr_bad && !(cmd && i_pwdata[1:0] == 2'b10) |=> o_wsr_bad)
        else $error("reserved window flag dropped without restore");
endmodule : iats_chk

bind iats_top iats_chk #(.WSR_MAX(WSR_MAX)) chk_u (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_instr_done(i_instr_done),
    .o_svc_start(o_svc_start), .o_call_busy(o_call_busy), .o_server_enable(o_server_enable),
    .o_global_enable(o_global_enable), .o_srv_fields(o_srv_fields), .o_wsr_bad(o_wsr_bad)
);
`default_nettype wire

// ### test/iats_src_model.sv
// Purpose: Far-side request sources: peripheral lines and the nonmaskable input.
// Assumes: Requests change just after a rising edge.
// Notes: Lines idle low between requests, as a released request line does.
`timescale 1ns/100ps
`default_nettype none

module iats_src_model (
    input  wire logic        i_mclk,
    output logic      [15:0] o_req,
    output logic             o_nmi
);
    initial begin
        o_req = 16'h0000;
        o_nmi = 1'b0;
    end
    // Three state times: a one-state pulse could slip past its sampling phase.
    task automatic fire(input int k);
        @(posedge i_mclk);
        o_nmi <= (k == 16);
        o_req <= (k < 16) ? 16'(1 << k) : 16'h0000;
        repeat (6) @(posedge i_mclk);
        o_req <= 16'h0000;
        o_nmi <= 1'b0;
    endtask : fire
endmodule : iats_src_model
`default_nettype wire

// ### test/tb.sv
// Purpose: Self-checking bench for iats_top.
// Assumes: Zero-wait APB; requests come from iats_src_model.
// Notes: Port values are judged at the falling edge, after the rising edge settled.
`timescale 1ns/100ps
`default_nettype none
`include "iats_cfg.svh"

module tb;
    import iats_pkg::*;
    logic         clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, done = 1'b0;
    logic [7:0]   paddr = 8'h00;
    logic [31:0]  pwdata = 32'h0, prdata, q;
    logic [31:0]  ctx [4] = '{32'h065a, 32'h3c, 32'ha5, 32'h05};
    logic         pready, pslverr, nmi, svc_start, busy, srv_en, gie, wsr_bad, irq, err;
    logic [15:0]  req;
    logic [4:0]   svc_vec;
    logic [2:0]   m;
    iats_srv_type fields;
    int           bad_count = 0, num_checks = 0;

    iats_top dut_u (
        .i_mclk(clk), .i_rst_n(rst_n), .i_ce(1'b1), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_req(req), .i_nmi(nmi), .i_instr_done(done), .o_svc_start(svc_start),
        .o_svc_vector(svc_vec), .o_call_busy(busy), .o_server_enable(srv_en), .o_global_enable(gie),
        .o_srv_fields(fields), .o_wsr_bad(wsr_bad), .o_irq(irq)
    );
    iats_src_model src_u (.i_mclk(clk), .o_req(req), .o_nmi(nmi));

    always #12.5 clk = ~clk;

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge clk);
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(q, e);
    endtask : rd

    // Counts from the rise of the call to the start pulse; n is in state times.
    task automatic wait_svc(input logic [4:0] v, input int n);
        int c;
        for (c = 0; c < 300 && busy !== 1'b1; c++) @(negedge clk);
        for (c = 0; c < 300 && svc_start !== 1'b1; c++) @(negedge clk);
        chk(c >= 2 * n - 2 && c <= 2 * n + 2, 1'b1);
        chk(svc_vec, v);
    endtask : wait_svc

    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : print_verdict

    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        for (int a = 4; a <= 24; a += 4) rd(8'(a), 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk({err, q[30:0]}, 32'h80000000);
        for (int i = 0; i < 8; i++) begin
            m = (i inside {0, 1, 3, 4, 6}) ? 3'(i) : 3'b111;
            apb(1'b1, `IATS_OFF_SRVCON, 32'(i * 32 + 10));
            chk({fields.mode, fields.low_bits}, {m, 5'h0a});
        end
        apb(1'b1, `IATS_OFF_MASK_LO, 32'hff);
        src_u.fire(0);
        src_u.fire(1);
        rd(`IATS_OFF_PENDING, 32'h3);
        fork
            src_u.fire(16);
            wait_svc(5'd16, 11);
        join
        rd(`IATS_OFF_PENDING, 32'h3);
        apb(1'b1, `IATS_OFF_CFG, 32'h1);
        apb(1'b1, `IATS_OFF_PSW, 32'h200);
        wait_svc(5'd1, 13);
        wait_svc(5'd0, 13);
        chk(irq, 1'b0);
        apb(1'b1, `IATS_OFF_EVT_MASK, 32'h1);
        chk(irq, 1'b1);
        apb(1'b1, `IATS_OFF_EVT, 32'h1);
        chk(irq, 1'b0);
        apb(1'b1, `IATS_OFF_CMD, 32'h4);
        chk(srv_en, 1'b1);
        src_u.fire(2);
        repeat (12) @(negedge clk);
        chk(busy, 1'b0);
        @(posedge clk);
        done <= 1'b1;
        @(posedge clk);
        done <= 1'b0;
        wait_svc(5'd2, 13);
        apb(1'b1, `IATS_OFF_CMD, 32'h8);
        chk(srv_en, 1'b0);
        for (int i = 0; i < 4; i++) apb(1'b1, 8'(4 + 4 * i), ctx[i]);
        apb(1'b1, `IATS_OFF_CMD, 32'h1);
        chk({gie, srv_en}, 2'b00);
        for (int i = 0; i < 4; i++) rd(8'(4 + 4 * i), i < 3 ? 32'h0 : 32'h05);
        apb(1'b1, `IATS_OFF_WSR, 32'h20);
        apb(1'b1, `IATS_OFF_WSR, 32'h01);
        chk(wsr_bad, 1'b1);
        rd(`IATS_OFF_WSR, 32'h20);
        apb(1'b1, `IATS_OFF_CMD, 32'h2);
        chk({gie, srv_en, wsr_bad}, 3'b110);
        for (int i = 0; i < 4; i++) rd(8'(4 + 4 * i), ctx[i]);
        print_verdict();
    end

    // The whole sequence needs well under two thousand cycles.
    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        print_verdict();
    end
endmodule : tb
`default_nettype wire
